// ==== rtl/cmc_control.sv ====
// What this block does
// - After reset nothing is acquired until software requests an operation.
// - Standard acquisition and offset calibration are both requested through the operation register.
// - A finished acquisition sets the conversion-done flag and raises the interrupt.
// - The burst register returns all seven results, 112 bits, in one read.
// - The single-result register returns the channel chosen in the read-channel select register.
// - No new operation starts until the previous completion is acknowledged.
// - Reading the flag register clears it, drops the interrupt and allows a restart.
// - Writing the idle command during an acquisition aborts it without flag or interrupt.
// - Progress register shows idle, running, finished or aborted.
// - Each of six discharge outputs follows its bit in the discharge select register.
// - The wake timer counts on the 50 kHz oscillator.
// - Timer elapse sets its flag and interrupts unless masked.
// - Timer is off after reset and runs only while control bit 3 is set.
// - The 8-bit period register alone sets the timer period.
// - A period below the current count restarts the timer, otherwise it continues.
// - Restart bit resets the timer; it runs again only if enabled.
// - Each of six cell results below the threshold sets the undervoltage flag, except in runs with operation request bit 5 set.
// - The undervoltage threshold resets to the code for 1.5 V.
// - After a cleared undervoltage flag, none follows until the condition has ended.
// - Control code is address shifted left once, bit zero set for a write.
// - Revision register holds revision, first-in-chain pin and power-enable pin.
// - Control bit 4 enables checksums, bit 2 is test mode, kept zero.
// - Progress codes are 00 idle, 01 running, 10 finished, 11 aborted.
// - While running, operation writes other than the idle command are ignored.
// - Any of five flags with its mask bit zero drives the interrupt.
`timescale 1ns/100ps
`default_nettype none
module cmc_control
	import cmc_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic         ce,
	input  wire logic         oscClk,
	input  wire logic         regStrobe,
	input  wire logic [7:0]   regCode,
	input  wire logic [15:0]  regWrData,
	output logic      [111:0] regRdData,
	output logic              regRdValid,
	input  wire logic         commErrEvent,
	input  wire logic         chkErrEvent,
	output logic              checksumEnable,
	output logic              testModeEnable,
	output logic              afeStart,
	output logic              afeAbort,
	output logic      [1:0]   afeVoltMode,
	output logic              afeTempSel,
	output logic      [1:0]   afeOpMode,
	input  wire logic         afeDone,
	input  wire logic [111:0] afeResult,
	input  wire logic         firstInChainPin,
	input  wire logic         powerEnablePin,
	output logic      [5:0]   dischargeOut,
	output logic              irqOut
);
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} cmc_op_t;

	typedef struct packed {
		cmc_op_t          state;
		logic [7:0]       opReq;
		logic [1:0]       progress;
		logic [4:2]       ctrl;
		logic [4:0]       mask;
		logic [5:0]       flags;
		logic [5:0]       udvCh;
		logic             udvState;
		logic [5:0]       disch;
		logic [7:0]       readSel;
		logic [15:0]      thresh;
		logic [6:0][15:0] res;
		logic [111:0]     rdData;
		logic             rdValid;
		logic             irq;
		logic             afeStart;
		logic             afeAbort;
		logic             firstS1;
		logic             firstS2;
		logic             powS1;
		logic             powS2;
	} cmc_st_t;

	cmc_st_t r, n;
	cmc_timer_if tif();

	logic       isRd;
	logic       isWr;
	logic [6:0] addr;
	logic       runDone;
	logic       evUdv;
	logic       restartC;
	logic       periodWrC;

	// Cells whose result lies below the threshold
	function automatic logic [5:0] udvScan(input logic [6:0][15:0] res, input logic [15:0] thr);
		logic [5:0] u;
		u = '0;
		for (int i = 0; i < N_CH; i++) begin
			u[i] = res[i] < thr;
		end
		return u;
	endfunction

	// Read data for one register; unmapped and reserved read zero
	function automatic logic [111:0] rdMux(input logic [6:0] a, input cmc_st_t s, input logic [7:0] per);
		logic [111:0] d;
		d = '0;
		case (a)
			A_REV: begin
				d[4:0] = {s.powS2, s.firstS2, REV_ID};
			end
			A_CTRL: begin
				d[4:2] = s.ctrl;
			end
			A_OPREQ: begin
				d[7:0] = s.opReq;
			end
			A_PROG: begin
				d[1:0] = s.progress;
			end
			A_MASK: begin
				d[4:0] = s.mask;
			end
			A_FLAGS: begin
				d[6:0] = {s.ctrl[CTRL_TEST], s.flags};
			end
			A_UDVCH: begin
				d[5:0] = s.udvCh;
			end
			A_DISCH: begin
				d[5:0] = s.disch;
			end
			A_RSEL: begin
				d[7:0] = s.readSel;
			end
			A_PER: begin
				d[7:0] = per;
			end
			A_THR: begin
				d[15:0] = s.thresh;
			end
			A_SINGLE: begin
				if (s.readSel < 8'(N_RES)) begin
					d[15:0] = s.res[s.readSel[2:0]];
				end
			end
			A_BURST: begin
				d = s.res;
			end
			default: begin
				d = '0;
			end
		endcase
		return d;
	endfunction

	// Control code decode: address above, direction in bit zero
	assign addr = regCode[7:1];
	assign isWr = regStrobe & regCode[0];
	assign isRd = regStrobe & ~regCode[0];
	assign runDone = (r.state == ST_RUN) && afeDone;

	// Next state: reads clear first, hardware events set last so they win
	always_comb begin
		n = r;
		evUdv = 1'b0;
		restartC = 1'b0;
		periodWrC = 1'b0;
		n.rdValid = 1'b0;
		n.afeStart = 1'b0;
		n.afeAbort = 1'b0;
		n.firstS1 = firstInChainPin;
		n.firstS2 = r.firstS1;
		n.powS1 = powerEnablePin;
		n.powS2 = r.powS1;
		if (isRd) begin
			n.rdValid = 1'b1;
			n.rdData = rdMux(addr, r, tif.period);
			if (addr == A_FLAGS) begin
				n.flags = '0;
				if (r.state == ST_DONE) begin
					n.state = ST_IDLE;
					n.opReq[OP_RQST] = 1'b0;
				end
			end
			if (addr == A_PROG && r.progress[1]) begin
				n.progress = PROG_IDLE;
			end
		end
		if (isWr) begin
			case (addr)
				A_CTRL: begin
					n.ctrl = regWrData[4:2];
				end
				A_OPREQ: begin
					if (r.state == ST_RUN && !afeDone) begin
						// Only the idle command is taken while running
						if (!regWrData[OP_RQST]) begin
							n.state = ST_IDLE;
							n.progress = PROG_ABORT;
							n.opReq[OP_RQST] = 1'b0;
							n.afeAbort = 1'b1;
						end
					end else if (r.state == ST_IDLE) begin
						n.opReq = regWrData[7:0];
						if (regWrData[OP_RQST]) begin
							n.state = ST_RUN;
							n.progress = PROG_RUN;
							n.afeStart = 1'b1;
						end
					end
				end
				A_SRST: begin
					restartC = regWrData[SRST_TMR];
				end
				A_MASK: begin
					n.mask = regWrData[4:0];
				end
				A_DISCH: begin
					n.disch = regWrData[5:0];
				end
				A_RSEL: begin
					n.readSel = regWrData[7:0];
				end
				A_PER: begin
					periodWrC = 1'b1;
				end
				A_THR: begin
					n.thresh = regWrData;
				end
				default: begin
				end
			endcase
		end
		// Completion captures results and checks cells
		if (runDone) begin
			n.res = afeResult;
			n.state = ST_DONE;
			n.progress = PROG_DONE;
			if (!r.opReq[OP_MODE_H]) begin
				n.udvCh = udvScan(afeResult, r.thresh);
				evUdv = (|n.udvCh) & ~r.udvState;
				n.udvState = |n.udvCh;
			end
		end
		if (runDone) begin
			n.flags[F_DONE] = 1'b1;
		end
		if (tif.elapsed) begin
			n.flags[F_TMR] = 1'b1;
		end
		if (commErrEvent) begin
			n.flags[F_COMM] = 1'b1;
		end
		if (evUdv) begin
			n.flags[F_UDV] = 1'b1;
		end
		if (chkErrEvent) begin
			n.flags[F_CHK] = 1'b1;
		end
		n.irq = |(n.flags[4:0] & ~n.mask);
	end

	// State register with documented reset values
	always_ff @(posedge clk) begin
		if (srst) begin
			r <= '0;
			r.opReq <= OPREQ_RST;
			r.flags <= FLAGS_RST;
			r.thresh <= UDV_THRESH_RST;
		end else if (ce) begin
			r <= n;
		end
	end

	// Timer control travels through the interface
	assign tif.enable = r.ctrl[CTRL_TMR];
	assign tif.restart = restartC & ce;
	assign tif.periodWr = periodWrC & ce;
	assign tif.periodData = regWrData[7:0];

	cmc_tick_sync u_tick (
		.clk    (clk),
		.srst   (srst),
		.ce     (ce),
		.oscClk (oscClk),
		.tif    (tif)
	);

	cmc_wake_timer u_timer (
		.clk  (clk),
		.srst (srst),
		.ce   (ce),
		.tif  (tif)
	);

	// Outputs straight from flops
	assign regRdData = r.rdData;
	assign regRdValid = r.rdValid;
	assign checksumEnable = r.ctrl[CTRL_CHK];
	assign testModeEnable = r.ctrl[CTRL_TEST];
	assign afeStart = r.afeStart;
	assign afeAbort = r.afeAbort;
	assign afeVoltMode = r.opReq[2:1];
	assign afeTempSel = r.opReq[OP_TEMP];
	assign afeOpMode = r.opReq[5:4];
	assign dischargeOut = r.disch;
	assign irqOut = r.irq;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_start;
		ce && isWr && addr == A_OPREQ && regWrData[OP_RQST] && r.state == ST_IDLE;
	endsequence
	sequence s_abort;
		ce && isWr && addr == A_OPREQ && !regWrData[OP_RQST] && r.state == ST_RUN && !afeDone;
	endsequence
	sequence s_finish;
		ce && runDone && !r.mask[F_DONE] ##1 ce[*2];
	endsequence

	chk_done_irq: assert property (s_finish |-> r.flags[F_DONE] && irqOut)
		else $error("completion raised no flag or interrupt");
	chk_start_runs: assert property (s_start |=> r.state == ST_RUN && r.progress == PROG_RUN && afeStart)
		else $error("start request not taken");
	chk_abort_clean: assert property (s_abort |=> r.progress == PROG_ABORT && r.state == ST_IDLE
		&& !r.flags[F_DONE] && afeAbort)
		else $error("abort left flag or wrong progress");
	chk_refuse_start: assert property (ce && isWr && addr == A_OPREQ && r.state == ST_DONE
		|=> r.state == ST_DONE && !afeStart)
		else $error("operation started before acknowledge");
	chk_run_ignores: assert property (ce && isWr && addr == A_OPREQ && regWrData[OP_RQST]
		&& r.state == ST_RUN && !afeDone |=> r.state == ST_RUN && $stable(r.opReq))
		else $error("write accepted while running");
	chk_ack_clears: assert property (ce && isRd && addr == A_FLAGS && r.state == ST_DONE
		|=> r.state == ST_IDLE && !r.flags[F_DONE])
		else $error("flag read did not acknowledge");
	chk_masked_irq: assert property ((ce && |(r.flags[4:0] & ~r.mask)) [*2] |-> irqOut)
		else $error("unmasked flag without interrupt");
	chk_udv_once: assert property (ce && runDone && r.udvState && !isRd && !r.opReq[OP_MODE_H]
		|=> r.flags[F_UDV] == $past(r.flags[F_UDV]))
		else $error("repeated undervoltage event");
	chk_disch_write: assert property (ce && isWr && addr == A_DISCH |=> dischargeOut == $past(regWrData[5:0]))
		else $error("discharge outputs not updated");
	chk_rev_read: assert property (ce && isRd && addr == A_REV |=> regRdValid && regRdData[2:0] == REV_ID)
		else $error("revision read wrong");
endmodule
`default_nettype wire

// ==== rtl/cmc_pkg.sv ====
package cmc_pkg;

	// Register addresses (control code is address shifted left by one)
	localparam logic [6:0] A_REV    = 7'h00;
	localparam logic [6:0] A_CTRL   = 7'h01;
	localparam logic [6:0] A_OPREQ  = 7'h02;
	localparam logic [6:0] A_PROG   = 7'h03;
	localparam logic [6:0] A_SRST   = 7'h04;
	localparam logic [6:0] A_MASK   = 7'h05;
	localparam logic [6:0] A_FLAGS  = 7'h06;
	localparam logic [6:0] A_UDVCH  = 7'h08;
	localparam logic [6:0] A_DISCH  = 7'h09;
	localparam logic [6:0] A_RSEL   = 7'h0A;
	localparam logic [6:0] A_PER    = 7'h0B;
	localparam logic [6:0] A_CAL    = 7'h0C;
	localparam logic [6:0] A_FUSE   = 7'h0D;
	localparam logic [6:0] A_THR    = 7'h10;
	localparam logic [6:0] A_SINGLE = 7'h11;
	localparam logic [6:0] A_TEST   = 7'h12;
	localparam logic [6:0] A_BURST  = 7'h7F;

	// Field positions
	localparam int CTRL_TEST = 2;
	localparam int CTRL_TMR  = 3;
	localparam int CTRL_CHK  = 4;
	localparam int OP_RQST   = 0;
	localparam int OP_TEMP   = 3;
	localparam int OP_MODE_H = 5;
	localparam int SRST_TMR  = 1;
	localparam int F_DONE    = 0;
	localparam int F_TMR     = 1;
	localparam int F_COMM    = 2;
	localparam int F_UDV     = 3;
	localparam int F_CHK     = 4;

	// Reset values
	localparam logic [7:0]  OPREQ_RST      = 8'h02;
	localparam logic [5:0]  FLAGS_RST      = 6'h20;
	localparam logic [15:0] UDV_THRESH_RST = 16'h0800;
	// Revision code, value is arbitrary
	localparam logic [2:0]  REV_ID         = 3'h5;

	// Progress encodings
	localparam logic [1:0] PROG_IDLE  = 2'h0;
	localparam logic [1:0] PROG_RUN   = 2'h1;
	localparam logic [1:0] PROG_DONE  = 2'h2;
	localparam logic [1:0] PROG_ABORT = 2'h3;

	// Result geometry
	localparam int N_CH  = 6;
	localparam int N_RES = 7;

endpackage

// ==== rtl/cmc_tick_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
module cmc_tick_sync (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic ce,
	input  wire logic oscClk,
	cmc_timer_if.osc  tif
);
	typedef struct packed {
		logic rs1;
		logic rs2;
		logic tog;
	} cmc_osc_t;
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} cmc_sys_t;

	cmc_osc_t o, oNext;
	cmc_sys_t s, sNext;

	// Oscillator side: reset brought over by two flops, then a toggle per edge
	always_comb begin
		oNext = o;
		oNext.rs1 = srst;
		oNext.rs2 = o.rs1;
		oNext.tog = o.rs2 ? 1'b0 : ~o.tog;
	end

	always_ff @(posedge oscClk) begin
		o <= oNext;
	end

	// System side: toggle crosses through two flops, a third finds the change
	always_comb begin
		sNext = s;
		sNext.s1 = o.tog;
		sNext.s2 = s.s1;
		sNext.s3 = s.s2;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s <= '0;
		end else if (ce) begin
			s <= sNext;
		end
	end

	// One pulse per oscillator period
	assign tif.tick = ce & (s.s2 ^ s.s3);
endmodule
`default_nettype wire

// ==== rtl/cmc_timer_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface cmc_timer_if;
	logic       tick;
	logic       enable;
	logic       restart;
	logic       periodWr;
	logic [7:0] periodData;
	logic [7:0] period;
	logic [7:0] count;
	logic       elapsed;
	modport osc (output tick);
	modport tmr (input tick, enable, restart, periodWr, periodData, output period, count, elapsed);
	modport ctl (output enable, restart, periodWr, periodData, input period, count, elapsed);
endinterface
`default_nettype wire

// ==== rtl/cmc_wake_timer.sv ====
`timescale 1ns/100ps
`default_nettype none
module cmc_wake_timer (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic ce,
	cmc_timer_if.tmr  tif
);
	typedef struct packed {
		logic [7:0] period;
		logic [7:0] count;
		logic       elapsed;
	} cmc_tmr_t;

	cmc_tmr_t r, rNext;

	// Counting, restart and period change
	always_comb begin
		rNext = r;
		rNext.elapsed = 1'b0;
		if (tif.periodWr) begin
			rNext.period = tif.periodData;
		end
		if (tif.restart) begin
			rNext.count = 8'h00;
		end else if (tif.periodWr && (tif.periodData < r.count)) begin
			rNext.count = 8'h00;
		end else if (tif.tick && tif.enable) begin
			if (r.count >= r.period) begin
				rNext.count = 8'h00;
				rNext.elapsed = 1'b1;
			end else begin
				rNext.count = r.count + 8'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			r <= '0;
		end else if (ce) begin
			r <= rNext;
		end
	end

	assign tif.period = r.period;
	assign tif.count = r.count;
	assign tif.elapsed = r.elapsed & ce;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	chk_timer_holds_off: assert property (ce && !tif.enable && !tif.restart && !tif.periodWr |=> $stable(r.count))
		else $error("timer moved while disabled");
	chk_timer_wraps: assert property (ce && tif.tick && tif.enable && r.count >= r.period && !tif.restart
		&& !tif.periodWr |=> r.count == 8'h00 && r.elapsed)
		else $error("timer did not elapse and restart");
	chk_period_shrink: assert property (ce && tif.periodWr && tif.periodData < r.count |=> r.count == 8'h00)
		else $error("smaller period did not restart timer");
endmodule
`default_nettype wire

// ==== verif/cmc_afe_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// Front end stand-in: converts after a set latency, stops on abort
module cmc_afe_model (
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic         afeStart,
	input  wire logic         afeAbort,
	input  wire logic [7:0]   lat,
	input  wire logic [111:0] res,
	output logic              afeDone,
	output logic      [111:0] afeResult,
	output int                starts
);
	logic [7:0] cnt;
	logic       busy;

	// Latency counter; an abort drops the conversion with no done pulse
	always @(posedge clk) begin
		afeDone <= 1'b0;
		if (srst) begin
			busy   <= 1'b0;
			starts <= 0;
		end else if (afeAbort) begin
			busy <= 1'b0;
		end else if (afeStart) begin
			busy   <= 1'b1;
			cnt    <= lat;
			starts <= starts + 1;
		end else if (busy) begin
			if (cnt == 8'h00) begin
				afeDone <= 1'b1;
				busy    <= 1'b0;
			end else begin
				cnt <= cnt - 8'h01;
			end
		end
	end

	// Results only valid with done; otherwise show the inverse so stale data never matches
	assign afeResult = afeDone ? res : ~res;
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import cmc_pkg::*;
	logic         clk = 1'b0;
	logic         srst = 1'b1;
	logic         oscClk = 1'b0;
	logic         regStrobe = 1'b0;
	logic [7:0]   regCode = 8'h00;
	logic [15:0]  regWrData = 16'h0000;
	logic         commErr = 1'b0;
	logic         chkErr = 1'b0;
	logic         ce = 1'b1;
	logic         firstPin = 1'b1;
	logic         powPin = 1'b0;
	logic [7:0]   lat = 8'h05;
	logic [111:0] res;
	logic [111:0] regRdData;
	logic [111:0] afeResult;
	logic         regRdValid;
	logic         checksumEnable;
	logic         testModeEnable;
	logic         afeStart;
	logic         afeAbort;
	logic         afeTempSel;
	logic         afeDone;
	logic         irqOut;
	logic [1:0]   afeVoltMode;
	logic [1:0]   afeOpMode;
	logic [5:0]   dischargeOut;
	int           starts;
	int           errors = 0;
	int           checks_done = 0;
	int           aborts = 0;

	// System clock 100 MHz
	always #5 clk = ~clk;
	// Oscillator stand-in, phase unrelated to clk
	initial begin
		#3;
		forever #62.5 oscClk = ~oscClk;
	end

	cmc_control dut (.clk(clk), .srst(srst), .ce(ce), .oscClk(oscClk), .regStrobe(regStrobe),
		.regCode(regCode), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
		.commErrEvent(commErr), .chkErrEvent(chkErr), .checksumEnable(checksumEnable),
		.testModeEnable(testModeEnable), .afeStart(afeStart), .afeAbort(afeAbort),
		.afeVoltMode(afeVoltMode), .afeTempSel(afeTempSel), .afeOpMode(afeOpMode), .afeDone(afeDone),
		.afeResult(afeResult), .firstInChainPin(firstPin), .powerEnablePin(powPin),
		.dischargeOut(dischargeOut), .irqOut(irqOut));

	cmc_afe_model afe (.clk(clk), .srst(srst), .afeStart(afeStart), .afeAbort(afeAbort), .lat(lat),
		.res(res), .afeDone(afeDone), .afeResult(afeResult), .starts(starts));

	// Count abort pulses so the abort output is seen by a check
	always @(posedge clk) begin
		if (afeAbort === 1'b1) begin
			aborts <= aborts + 1;
		end
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [111:0] got, input logic [111:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	// Write, then let the register update land before returning
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		@(posedge clk);
		#1;
		regStrobe = 1'b1;
		regCode   = {a, 1'b1};
		regWrData = d;
		@(posedge clk);
		#1;
		regStrobe = 1'b0;
		@(posedge clk);
		#1;
	endtask

	// Read and compare; the answer is awaited under a bound
	task automatic rc(input logic [6:0] a, input logic [111:0] exp);
		int i;
		@(posedge clk);
		#1;
		regStrobe = 1'b1;
		regCode   = {a, 1'b0};
		@(posedge clk);
		#1;
		regStrobe = 1'b0;
		for (i = 0; i < 4 && regRdValid !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		if (regRdValid !== 1'b1) begin
			errors++;
			final_report();
		end else begin
			chk(regRdData, exp);
		end
	endtask

	task automatic wait_irq(input int n);
		int i;
		for (i = 0; i < n && irqOut !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		if (irqOut !== 1'b1) begin
			errors++;
			final_report();
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	initial begin
		res = {16'h0906, 16'h0905, 16'h0904, 16'h0903, 16'h0902, 16'h0901, 16'h0900};
		repeat (20) @(posedge clk);
		#1;
		srst = 1'b0;
		// Reset values and plain register access
		rc(A_CTRL, 0);
		rc(A_MASK, 0);
		rc(A_OPREQ, OPREQ_RST);
		rc(A_PROG, PROG_IDLE);
		rc(A_THR, UDV_THRESH_RST);
		rc(A_REV, {3'h0, 1'b0, 1'b1, REV_ID});
		rc(A_FLAGS, FLAGS_RST);
		rc(A_FLAGS, 0);
		rc(7'h20, 0);
		chk(starts, 0);
		wr(A_CTRL, 16'h0010);
		chk({checksumEnable, testModeEnable}, 2'h2);
		wr(A_DISCH, 16'h002A);
		chk(dischargeOut, 6'h2A);
		wr(A_DISCH, 16'h0015);
		chk(dischargeOut, 6'h15);
		// A write while the clock enable is low must leave the discharge outputs unchanged
		ce = 1'b0;
		wr(A_DISCH, 16'h003F);
		ce = 1'b1;
		chk(dischargeOut, 6'h15);
		// Pins reach the revision register only after two synchroniser flops
		firstPin = 1'b0;
		powPin = 1'b1;
		idle(3);
		rc(A_REV, {3'h0, 1'b1, 1'b0, REV_ID});
		$display("test registers done");
		// Standard acquisition, results, refusal before acknowledge
		wr(A_OPREQ, 16'h0003);
		chk(afeVoltMode, 2'h1);
		wait_irq(50);
		rc(A_PROG, PROG_DONE);
		rc(A_BURST, res);
		wr(A_RSEL, 16'h0005);
		rc(A_SINGLE, res[95:80]);
		wr(A_OPREQ, 16'h0003);
		idle(20);
		chk(starts, 1);
		rc(A_FLAGS, 8'h01);
		idle(2);
		chk(irqOut, 0);
		// Offset calibration is accepted once acknowledged
		wr(A_OPREQ, 16'h0001);
		chk(afeVoltMode, 2'h0);
		wait_irq(50);
		chk(starts, 2);
		rc(A_FLAGS, 8'h01);
		$display("test acquisition done");
		// Abort with a slow front end; other writes ignored while running
		lat = 8'h3C;
		wr(A_OPREQ, 16'h0003);
		wr(A_OPREQ, 16'h0005);
		chk(afeVoltMode, 2'h1);
		wr(A_OPREQ, 16'h0002);
		chk(aborts, 1);
		rc(A_PROG, PROG_ABORT);
		idle(80);
		chk(irqOut, 0);
		rc(A_FLAGS, 0);
		rc(A_PROG, PROG_IDLE);
		chk(starts, 3);
		lat = 8'h05;
		$display("test abort done");
		// Undervoltage on channel 3, then no repeat while still low
		res[63:48] = 16'h0100;
		wr(A_OPREQ, 16'h0003);
		wait_irq(50);
		rc(A_UDVCH, 8'h08);
		rc(A_FLAGS, 8'h09);
		wr(A_OPREQ, 16'h001B);
		chk({afeOpMode, afeTempSel}, 3'h3);
		wait_irq(50);
		rc(A_FLAGS, 8'h01);
		// A temperature-only run compares no cell, so the channel flags stay
		res[63:48] = 16'h0903;
		wr(A_OPREQ, 16'h0023);
		wait_irq(50);
		rc(A_UDVCH, 8'h08);
		rc(A_FLAGS, 8'h01);
		// Masked communication error is flagged but silent
		wr(A_MASK, 16'h0004);
		@(posedge clk);
		#1;
		commErr = 1'b1;
		@(posedge clk);
		#1;
		commErr = 1'b0;
		idle(5);
		chk(irqOut, 0);
		rc(A_FLAGS, 8'h04);
		wr(A_MASK, 16'h0000);
		// Unmasked checksum error raises the interrupt
		@(posedge clk);
		#1;
		chkErr = 1'b1;
		@(posedge clk);
		#1;
		chkErr = 1'b0;
		wait_irq(5);
		rc(A_FLAGS, 8'h10);
		$display("test undervoltage done");
		// Wake timer: silent while disabled, periodic when enabled, maskable
		wr(A_PER, 16'h0002);
		idle(150);
		rc(A_FLAGS, 0);
		wr(A_CTRL, 16'h0018);
		wait_irq(300);
		rc(A_FLAGS, 8'h02);
		wait_irq(300);
		rc(A_FLAGS, 8'h02);
		wr(A_MASK, 16'h0002);
		idle(150);
		chk(irqOut, 0);
		rc(A_FLAGS, 8'h02);
		$display("test timer done");
		// Second reset in mid-run brings back the reset values
		srst = 1'b1;
		repeat (20) @(posedge clk);
		#1;
		srst = 1'b0;
		chk(dischargeOut, 6'h00);
		chk(irqOut, 0);
		rc(A_CTRL, 0);
		rc(A_FLAGS, FLAGS_RST);
		rc(A_PROG, PROG_IDLE);
		$display("test reset done");
		final_report();
	end
endmodule
`default_nettype wire
